// >>> rtl/mac_mgmt_top.sv
// Controller enable, local reset and management frame engine with APB registers.
// Assumes an APB master on pclk and same-clock bus error and transmit status inputs.
// Contract
// - Enable set permits receive and transmit
// - Enable clear halts receive, aborts transmit badly
// - Enable clear resets DMA, descriptor, FIFO logic
// - Local reset or bus error clears enable
// - Local reset restores registers, aborts traffic
// - Local reset bit self-clears after eight cycles
// - Frame register has no reset value
// - Frame write launches frame unless speed zero
// - Pending frame launches once speed becomes nonzero
// - Frame fields at documented bit positions
// - Operation code selects write or read
// - Start and turnaround bits shifted unchanged
// - Address fields five bits each
// - Preamble then frame shifted out serially
// - Write frame done raises flag, register intact
// - Read frame done stores read data
// - Thirty-two one preamble unless disabled
// - Zero speed stops clock, else divide 2N
// - Interrupt while flag and mask both set
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module mac_mgmt_top
  import mac_mgmt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Datapath side
  input  wire logic        bus_error_event,
  input  wire logic        tx_frame_active,
  output logic             controller_enable,
  output logic             datapath_reset,
  output logic             tx_bad_crc_abort,
  output logic             abrupt_abort,
  output logic             irq,
  // Management link
  output logic             management_clock_pin,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_n
);

  logic [3:0]        local_reset_count;
  logic              local_reset_active;
  logic [31:0]       event_flags;
  logic [31:0]       event_mask;
  logic [31:0]       next_event_flags;
  clock_control_type management_clock_control;
  frame_type         management_frame;
  logic              next_enable;
  engine_state_type  state;
  logic [5:0]        pos;
  logic              presented;
  logic              pending;
  logic              done_pulse;
  logic              mdio_sync;
  logic              rise_en;
  logic              fall_en;
  logic              reading;
  logic              sample;
  logic              setup_phase;
  logic              write_access;
  logic              write_control;
  logic              write_frame;
  logic [31:0]       read_value;
  logic              mapped;

  // APB decode, zero wait states
  assign pready        = 1'b1;
  assign setup_phase   = psel && !penable;
  assign write_access  = psel && penable && pwrite && !pslverr;
  assign write_control = write_access && paddr == CONTROL_OFFSET;
  assign write_frame   = write_access && paddr == FRAME_OFFSET;

  always_comb begin
    read_value = 32'h0000_0000;
    mapped     = 1'b1;
    case (paddr)
      CONTROL_OFFSET: begin
        read_value[ENABLE_BIT]      = controller_enable;
        read_value[LOCAL_RESET_BIT] = local_reset_active;
      end
      EVENT_FLAGS_OFFSET: begin
        read_value = event_flags;
      end
      EVENT_MASK_OFFSET: begin
        read_value = event_mask;
      end
      FRAME_OFFSET: begin
        read_value = management_frame;
      end
      CLOCK_CONTROL_OFFSET: begin
        read_value[PREAMBLE_DISABLE_BIT]    = management_clock_control.preamble_disable;
        read_value[SPEED_MSB:SPEED_LSB]     = management_clock_control.speed;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : read_value;
      pslverr <= !mapped;
    end
  end

  // Local reset sequence
  assign local_reset_active = local_reset_count != 4'h0;
  assign abrupt_abort       = local_reset_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_reset_count <= 4'h0;
    end else if (write_control && pwdata[LOCAL_RESET_BIT] && !local_reset_active) begin
      local_reset_count <= LOCAL_RESET_CYCLES;
    end else if (local_reset_active) begin
      local_reset_count <= local_reset_count - 4'h1;
    end
  end

  // Controller enable
  always_comb begin
    next_enable = controller_enable;
    if (write_control) begin
      next_enable = pwdata[ENABLE_BIT] && !pwdata[LOCAL_RESET_BIT];
    end
    if (bus_error_event) begin
      next_enable = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_enable <= 1'b0;
      tx_bad_crc_abort  <= 1'b0;
    end else if (local_reset_active) begin
      controller_enable <= 1'b0;
      tx_bad_crc_abort  <= 1'b0;
    end else begin
      controller_enable <= next_enable;
      tx_bad_crc_abort  <= controller_enable && !next_enable && tx_frame_active;
    end
  end

  assign datapath_reset = !controller_enable;

  // Event flags and mask
  always_comb begin
    next_event_flags = event_flags;
    if (write_access && paddr == EVENT_FLAGS_OFFSET) begin
      next_event_flags = event_flags & ~pwdata;
    end
    if (done_pulse) begin
      next_event_flags[MGMT_DONE_BIT] = 1'b1;
    end
    if (bus_error_event) begin
      next_event_flags[BUS_ERROR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flags <= FLAGS_RESET;
    end else if (local_reset_active) begin
      event_flags <= FLAGS_RESET;
    end else begin
      event_flags <= next_event_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask <= MASK_RESET;
    end else if (local_reset_active) begin
      event_mask <= MASK_RESET;
    end else if (write_access && paddr == EVENT_MASK_OFFSET) begin
      event_mask <= pwdata & FLAG_BITS_USED;
    end
  end

  assign irq = |(event_flags & event_mask);

  // Management clock setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      management_clock_control <= CLOCK_CONTROL_RESET;
    end else if (local_reset_active) begin
      management_clock_control <= CLOCK_CONTROL_RESET;
    end else if (write_access && paddr == CLOCK_CONTROL_OFFSET) begin
      management_clock_control.preamble_disable <= pwdata[PREAMBLE_DISABLE_BIT];
      management_clock_control.speed            <= pwdata[SPEED_MSB:SPEED_LSB];
    end
  end

  mgmt_clock_divider u_divider (
    .pclk       (pclk),
    .presetn    (presetn),
    .hold       (local_reset_active),
    .speed      (management_clock_control.speed),
    .mgmt_clock (management_clock_pin),
    .rise_en    (rise_en),
    .fall_en    (fall_en)
  );

  sync_two_flop u_mdio_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (mdio_in),
    .sync_out (mdio_sync)
  );

  // Frame register, no reset value
  assign reading = management_frame.operation_code[1];
  assign sample  = state == ENGINE_FRAME && rise_en && presented && reading
                   && pos >= DATA_FIRST_POS;

  always_ff @(posedge pclk) begin
    if (write_frame) begin
      management_frame <= pwdata;
    end else if (sample) begin
      management_frame.data[~pos[3:0]] <= mdio_sync;
    end
  end

  // Frame engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ENGINE_IDLE;
      pos        <= 6'h00;
      presented  <= 1'b0;
      pending    <= 1'b0;
      done_pulse <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe_n  <= 1'b1;
    end else if (local_reset_active) begin
      state      <= ENGINE_IDLE;
      pos        <= 6'h00;
      presented  <= 1'b0;
      pending    <= 1'b0;
      done_pulse <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe_n  <= 1'b1;
    end else begin
      done_pulse <= 1'b0;
      case (state)
        ENGINE_IDLE: begin
          if (write_frame) begin
            pending <= 1'b1;
          end else if (pending && management_clock_control.speed != 6'h00) begin
            pending   <= 1'b0;
            presented <= 1'b0;
            if (management_clock_control.preamble_disable) begin
              state <= ENGINE_FRAME;
              pos   <= FRAME_START_POS;
            end else begin
              state <= ENGINE_PREAMBLE;
              pos   <= 6'h00;
            end
          end
        end
        ENGINE_PREAMBLE, ENGINE_FRAME: begin
          if (fall_en) begin
            presented <= 1'b1;
            if (state == ENGINE_PREAMBLE) begin
              mdio_out  <= 1'b1;
              mdio_oe_n <= 1'b0;
            end else begin
              mdio_out  <= management_frame[~pos[4:0]];
              mdio_oe_n <= reading && pos > TURNAROUND_POS;
            end
          end else if (rise_en && presented) begin
            presented <= 1'b0;
            pos       <= pos + 6'h01;
            if (pos == PREAMBLE_LAST_POS) begin
              state <= ENGINE_FRAME;
            end else if (pos == LAST_POS) begin
              state <= ENGINE_DONE;
            end
          end
        end
        ENGINE_DONE: begin
          done_pulse <= 1'b1;
          mdio_out   <= 1'b0;
          mdio_oe_n  <= 1'b1;
          state      <= ENGINE_IDLE;
        end
        default: begin
          state <= ENGINE_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence local_reset_start;
    write_control && pwdata[LOCAL_RESET_BIT] && !local_reset_active;
  endsequence

  sequence local_reset_run;
    local_reset_active[*8] ##1 !local_reset_active;
  endsequence

  a_local_reset_length : assert property (local_reset_start |=> local_reset_run)
    else $error("local reset bit did not clear after eight cycles");

  a_reset_clears_enable : assert property (local_reset_start |=> !controller_enable)
    else $error("enable stayed set after local reset");

  a_bus_error_enable : assert property ((bus_error_event && !local_reset_active)
    |=> !controller_enable && event_flags[BUS_ERROR_BIT])
    else $error("bus error did not clear enable");

  a_done_raises_irq : assert property ((done_pulse && event_mask[MGMT_DONE_BIT]
    && !(write_access && paddr == EVENT_MASK_OFFSET)
    && !local_reset_active) |=> irq ##0 event_flags[MGMT_DONE_BIT])
    else $error("completion did not raise interrupt");

  a_no_launch_stopped : assert property ((state == ENGINE_IDLE
    && management_clock_control.speed == 6'h00) |=> state == ENGINE_IDLE)
    else $error("frame launched with zero speed");

  a_preamble_skipped : assert property ((state == ENGINE_IDLE && pending
    && !write_frame && !local_reset_active && management_clock_control.speed != 6'h00
    && management_clock_control.preamble_disable)
    |=> state == ENGINE_FRAME && pos == FRAME_START_POS)
    else $error("preamble sent while disabled");

  a_read_releases_line : assert property ((state == ENGINE_FRAME && fall_en
    && reading && pos > TURNAROUND_POS && !local_reset_active) |=> mdio_oe_n)
    else $error("data line driven during read data");

  a_data_on_fall : assert property ((!fall_en && !local_reset_active
    && (state == ENGINE_PREAMBLE || state == ENGINE_FRAME)) |=> $stable(mdio_out))
    else $error("data line changed away from falling edge");

  a_bad_crc_abort : assert property ((controller_enable && bus_error_event
    && tx_frame_active && !local_reset_active) |=> tx_bad_crc_abort)
    else $error("transmit not aborted with bad crc");

endmodule

// >>> rtl/mac_mgmt_pkg.sv
// Shared constants and types for the controller enable and management frame block.
// Assumes one 20 MHz bus clock and an APB master with 32-bit data.
package mac_mgmt_pkg;

  // Register byte offsets
  localparam logic [11:0] EVENT_FLAGS_OFFSET   = 12'h004;
  localparam logic [11:0] EVENT_MASK_OFFSET    = 12'h008;
  localparam logic [11:0] CONTROL_OFFSET       = 12'h024;
  localparam logic [11:0] FRAME_OFFSET         = 12'h040;
  localparam logic [11:0] CLOCK_CONTROL_OFFSET = 12'h044;

  // Field positions
  localparam int LOCAL_RESET_BIT      = 0;
  localparam int ENABLE_BIT           = 1;
  localparam int BUS_ERROR_BIT        = 22;
  localparam int MGMT_DONE_BIT        = 23;
  localparam int PREAMBLE_DISABLE_BIT = 7;
  localparam int SPEED_LSB            = 1;
  localparam int SPEED_MSB            = 6;

  // Reset values and used flag bit mask
  localparam logic [31:0] FLAGS_RESET         = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET          = 32'h0000_0000;
  localparam logic [6:0]  CLOCK_CONTROL_RESET = 7'h00;
  localparam logic [31:0] FLAG_BITS_USED      = 32'h00c0_0000;

  // Cycle counts and frame positions
  localparam logic [3:0] LOCAL_RESET_CYCLES = 4'h8;
  localparam logic [5:0] FRAME_START_POS    = 6'h20;
  localparam logic [5:0] PREAMBLE_LAST_POS  = 6'h1f;
  localparam logic [5:0] TURNAROUND_POS     = 6'h2e;
  localparam logic [5:0] DATA_FIRST_POS     = 6'h30;
  localparam logic [5:0] LAST_POS           = 6'h3f;

  // Operation codes
  localparam logic [1:0] OP_WRITE_LOOSE = 2'h0;
  localparam logic [1:0] OP_WRITE       = 2'h1;
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [1:0] OP_READ_LOOSE  = 2'h3;

  typedef enum logic [1:0] {
    ENGINE_IDLE     = 2'b00,
    ENGINE_PREAMBLE = 2'b01,
    ENGINE_FRAME    = 2'b11,
    ENGINE_DONE     = 2'b10
  } engine_state_type;

  typedef struct packed {
    logic [1:0]  start_delimiter;
    logic [1:0]  operation_code;
    logic [4:0]  phy_address;
    logic [4:0]  phy_register_address;
    logic [1:0]  turnaround;
    logic [15:0] data;
  } frame_type;

  typedef struct packed {
    logic       preamble_disable;
    logic [5:0] speed;
  } clock_control_type;

endpackage

// >>> rtl/sync_two_flop.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow pin such as the management data line.
`timescale 1ns/1ps
module sync_two_flop (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// >>> rtl/mgmt_clock_divider.sv
// Management clock divider: bus clock divided by twice the speed value.
// Assumes speed comes from a register on the same clock.
`timescale 1ns/1ps
module mgmt_clock_divider
  import mac_mgmt_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       hold,
  // Setting
  input  wire logic [5:0] speed,
  // Clock and edge enables
  output logic            mgmt_clock,
  output logic            rise_en,
  output logic            fall_en
);

  logic [5:0] count;
  logic       wrap;

  assign wrap    = (speed != 6'h00) && (count >= speed - 6'h01);
  assign rise_en = wrap && !mgmt_clock;
  assign fall_en = wrap && mgmt_clock;

  // Stopped and low at zero speed or on hold, else toggles every speed cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count      <= 6'h00;
      mgmt_clock <= 1'b0;
    end else if (hold || speed == 6'h00) begin
      count      <= 6'h00;
      mgmt_clock <= 1'b0;
    end else if (wrap) begin
      count      <= 6'h00;
      mgmt_clock <= ~mgmt_clock;
    end else begin
      count <= count + 6'h01;
    end
  end

  a_clock_stopped_low : assert property (@(posedge pclk) disable iff (!presetn)
    (speed == 6'h00) |=> !mgmt_clock)
    else $error("management clock runs with zero speed");

  a_clock_half_period : assert property (@(posedge pclk) disable iff (!presetn)
    (speed == 6'h02 && !hold && rise_en) ##1 (speed == 6'h02 && !hold) |-> mgmt_clock[*2])
    else $error("management clock half period wrong");

endmodule

// >>> tb/mgmt_phy_model.sv
// Behavioural management PHY: records the bits driven to it and answers reads.
// Assumes the management clock stands still between frames; the data line has a pull-up.
`timescale 1ns/1ps
module mgmt_phy_model (
  // Link
  input  wire logic        mdc,
  input  wire logic        mdio_out,
  input  wire logic        mdio_oe_n,
  output logic             mdio_in,
  // Bench side
  input  wire logic        clear,
  input  wire logic [15:0] rd_data,
  output logic [63:0]      captured,
  output logic [6:0]       bit_count
);
  logic [4:0] left;
  logic       drive;
  logic       level;

  // Pull-up level unless answering
  assign mdio_in = drive ? level : 1'b1;

  // Sample device bits on the rising edge
  always @(posedge mdc or posedge clear) begin
    if (clear) begin
      captured <= '0;
      bit_count <= '0;
    end else if (!mdio_oe_n) begin
      captured <= {captured[62:0], mdio_out};
      bit_count <= bit_count + 7'h1;
    end
  end

  // Read data, msb first, changed after the rising edge
  always @(posedge mdc or posedge clear) begin
    if (clear || !mdio_oe_n) begin
      left <= 5'h10;
      drive <= 1'b0;
    end else if (left != 5'h0) begin
      level <= rd_data[left - 5'h1];
      drive <= 1'b1;
      left <= left - 5'h1;
    end else begin
      drive <= 1'b0;
    end
  end
endmodule

// >>> tb/mac_enable_and_mdio_frame_engine_test.sv
// Self-checking bench for the enable control and management frame engine.
// Assumes an APB slave with zero wait states and the PHY model on the link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module mac_enable_and_mdio_frame_engine_test
  import mac_mgmt_pkg::*;
;
  localparam logic [32:0] FULL = 33'h1_ffff_ffff;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h5f;
  logic        pready, pslverr, controller_enable, datapath_reset;
  logic        bus_error_event = 0, tx_frame_active = 0, phy_clear = 0;
  logic        tx_bad_crc_abort, abrupt_abort, irq;
  logic        management_clock_pin, mdio_in, mdio_out, mdio_oe_n, mdc_q = 0;
  logic [15:0] rd_data = '0;
  logic [63:0] captured;
  logic [6:0]  bit_count;
  logic [7:0]  gap = '0, mdc_per = '0;
  logic [32:0] exp_q[$], msk_q[$], e_v, m_v;
  int          err_total = 0, checks_done = 0, cycles = 0;

  always #25 pclk = ~pclk;

  mac_mgmt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_error_event(bus_error_event), .tx_frame_active(tx_frame_active),
    .controller_enable(controller_enable), .datapath_reset(datapath_reset),
    .tx_bad_crc_abort(tx_bad_crc_abort), .abrupt_abort(abrupt_abort), .irq(irq),
    .management_clock_pin(management_clock_pin), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n));

  mgmt_phy_model phy (.mdc(management_clock_pin), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .mdio_in(mdio_in), .clear(phy_clear), .rd_data(rd_data),
    .captured(captured), .bit_count(bit_count));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    `CHK("irq rise", 1'b1, irq)
  endtask

  // Read results against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      `CHK("apb read", e_v, {pslverr, prdata} & m_v)
    end
  end

  // Management clock period and hang limit
  always @(posedge pclk) begin
    mdc_q <= management_clock_pin;
    gap <= (management_clock_pin && !mdc_q) ? 8'h1 : gap + 8'h1;
    if (management_clock_pin && !mdc_q) mdc_per <= gap;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    int n, k, nb;
    frame_type fr;
    logic [5:0] spd;
    logic pre;
    logic [63:0] seq, ex, mk;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("enable", 1'b0, controller_enable)
    `CHK("dp reset", 1'b1, datapath_reset)
    rd(EVENT_FLAGS_OFFSET, {1'b0, FLAGS_RESET}, FULL);
    rd(EVENT_MASK_OFFSET, {1'b0, MASK_RESET}, FULL);
    rd(CONTROL_OFFSET, 33'h0, FULL);
    rd(CLOCK_CONTROL_OFFSET, 33'h0, FULL);
    rd(12'h100, 33'h1_0000_0000, FULL);
    apb(1'b1, CONTROL_OFFSET, 32'h2);
    @(negedge pclk);
    `CHK("enable on", 1'b1, controller_enable)
    `CHK("dp run", 1'b0, datapath_reset)
    // Bus error with a frame in flight
    @(posedge pclk);
    tx_frame_active <= 1'b1;
    bus_error_event <= 1'b1;
    @(posedge pclk);
    bus_error_event <= 1'b0;
    n = 0;
    repeat (5) begin
      @(negedge pclk);
      if (tx_bad_crc_abort === 1'b1) n++;
    end
    `CHK("bad crc", 1, n)
    `CHK("enable err", 1'b0, controller_enable)
    rd(EVENT_FLAGS_OFFSET, 33'h0040_0000, FULL);
    apb(1'b1, EVENT_FLAGS_OFFSET, 32'h0040_0000);
    rd(EVENT_FLAGS_OFFSET, 33'h0, FULL);
    // Local reset while enabled
    apb(1'b1, EVENT_MASK_OFFSET, 32'h00c0_0000);
    apb(1'b1, CONTROL_OFFSET, 32'h2);
    apb(1'b1, CONTROL_OFFSET, 32'h1);
    tx_frame_active <= 1'b0;
    n = 0;
    repeat (16) begin
      @(negedge pclk);
      if (abrupt_abort === 1'b1) n++;
    end
    `CHK("reset cycles", 8, n)
    `CHK("enable rst", 1'b0, controller_enable)
    rd(CONTROL_OFFSET, 33'h0, FULL);
    rd(EVENT_MASK_OFFSET, 33'h0, FULL);
    apb(1'b1, EVENT_MASK_OFFSET, 32'h0080_0000);
    // Every operation code, compliant and loose patterns
    for (k = 0; k < 4; k++) begin
      fr = xs();
      fr.operation_code = k[1:0];
      if (!k[0]) begin
        fr.start_delimiter = 2'b01;
        fr.turnaround = 2'b10;
      end
      spd = 6'h2 + {5'h0, k[0]};
      pre = (k == 2);
      rd_data <= 16'(xs());
      phy_clear <= 1'b1;
      @(posedge pclk);
      phy_clear <= 1'b0;
      apb(1'b1, CLOCK_CONTROL_OFFSET, (k == 0) ? 32'h0 : {24'h0, pre, spd, 1'b0});
      apb(1'b1, FRAME_OFFSET, fr);
      if (k == 0) begin
        n = 0;
        repeat (40) begin
          @(negedge pclk);
          if (management_clock_pin !== 1'b0) n++;
        end
        `CHK("clock idle", 0, n)
        apb(1'b1, CLOCK_CONTROL_OFFSET, {24'h0, pre, spd, 1'b0});
      end
      wait_irq();
      nb = (pre ? 0 : 32) + (fr.operation_code[1] ? 15 : 32);
      seq = pre ? {32'h0, fr} : {32'hffff_ffff, fr};
      ex = seq >> ((pre ? 32 : 64) - nb);
      mk = (64'h1 << nb) - 64'h1;
      `CHK("bit count", 7'(nb), bit_count)
      `CHK("frame bits", ex, captured & mk)
      `CHK("clock period", {1'b0, spd, 1'b0}, mdc_per)
      rd(FRAME_OFFSET, {1'b0, fr.operation_code[1] ? {fr[31:16], rd_data} : 32'(fr)}, FULL);
      apb(1'b1, EVENT_FLAGS_OFFSET, 32'h0080_0000);
      @(negedge pclk);
      `CHK("irq clear", 1'b0, irq)
    end
    test_done();
  end
endmodule
